/* File: ranger_host_port.v */
`timescale 1ns/100ps
`include "ranger_regs.vh"
// What this block does
// (RQ1) firmware loading slave at address 0x45
// (RQ2) application address 0x29, reprogrammable
// (RQ3) two independent slave addresses
// (RQ4) master must honour clock stretching
// (RQ5) transmit: stretch after 8th bit
// (RQ6) receive: stretch, decide ack, release
// (RQ7) host loads firmware before ranging
// (RQ8) free-running: autonomous, event pin output
// (RQ9) free-running: pulse event on new sample
// (RQ10) triggered: idle until host pulses pin
// (RQ11) trigger start within one microsecond
// (RQ12) standby: period 0, tick spacing 2048
// (RQ13) rtc tick paces sampling and timing
// (RQ14) runs without host stimulus
// (RQ15) interrupt on motion or proximity
// (RQ16) distance is time times sound over two
// (RQ17) host leaves event pin undriven unless triggering
// (RQ18) host keeps reset pin defined
// (RQ19) host keeps program select defined
module ranger_host_port
#(
  parameter RTC_DIV = 16'd40,
  parameter TOF_W = 16
)
(
  input wire clk,
  input wire rst,
  input wire scl_in,
  output wire scl_oe_n,
  input wire sda_in,
  output wire sda_oe_n,
  input wire evt_in,
  output wire evt_out,
  output wire evt_oe_n,
  input wire program_select_pin,
  input wire trig_mode,
  input wire irq_on_proximity,
  input wire [15:0] prox_limit_mm,
  input wire [15:0] period_ticks,
  input wire [15:0] rtc_tick_spacing,
  input wire echo_in,
  output reg burst_out,
  output reg general_range_firmware_loaded,
  output reg [7:0] fw_byte,
  output reg fw_byte_valid,
  output reg [6:0] app_addr_out,
  output reg [15:0] distance_mm,
  output reg measuring
);
  // ****************************************
  // declarations
  // ****************************************
  localparam ST_IDLE = 3'b001; // waiting for tick or trigger
  localparam ST_FLY = 3'b010; // burst sent, timing echo
  localparam ST_DONE = 3'b100; // result and event pulse
  localparam integer TRIG_CYC = `TRIG_LAT_NS / `CLK_NS; // longest time, rounds down
  // ****************************************
  // behaviour in brief
  // ****************************************
  // i2c side:
  // - one byte engine serves both addresses
  // - programming address is fixed, app address lives here
  // - every data byte and every read address byte ends in a short clock stretch before ack
  // - read bytes come straight from the latest distance
  // - low byte first, then high, repeating within a read
  // - byte order restarts on every start condition
  // - read data is offered combinationally to the core,
  //   so the byte loaded during a stretch is never stale
  // - programming data is nacked while select is low
  // - loaded flag sets on the stop of a programming write
  // limitation:
  // - no check on image length or content
  // - an address change needs the arming byte first
  // - reserved address ranges are silently refused
  // ranging side:
  // - rtc tick is a one-cycle enable from the prescaler
  // - spacing counter divides ticks into interval points
  // - period counter divides interval points into samples
  // - period of zero means no sampling: standby
  // - a shorter spacing or period takes effect at once,
  //   so a mode change never waits out a long old count
  // - trigger path: two flops plus one edge flop
  // - triggers while measuring are ignored
  // - echo is synchronised before it ends the flight
  // - time of flight saturates instead of wrapping
  // - motion compares against the previous result
  // - proximity compares against the host limit
  // - event pulse only in free-running mode
  // trade-off:
  // - distance uses a divide, cheap enough at this rate,
  //   and keeps the scale exact for the default divider
  // - event pin direction follows the mode input directly,
  //   no handover cycle, so the host must obey its side
  reg [2:0] st_reg;
  reg evt_s1_reg, evt_s2_reg, evt_d_reg; // trigger synchroniser
  reg echo_s1_reg, echo_s2_reg; // echo synchroniser
  reg [15:0] div_reg; // rtc prescaler
  reg rtc_tick; // one-cycle rtc enable
  reg [15:0] spacing_reg; // ticks between interval points
  reg [15:0] period_reg; // intervals between samples
  reg [TOF_W-1:0] tof_reg; // rtc-cycle time of flight
  reg [2:0] pulse_reg; // event pulse width counter
  reg evt_high_reg; // event pin drive
  reg set_app_reg; // next app write byte changes address
  reg [7:0] tx_byte; // read byte offered to core
  reg rd_hi_reg; // read order: low then high
  reg [31:0] dist_calc; // tof scaled product
  wire start_pulse, stop_pulse, addr_hit, sel_program_select_pin, rd_mode, rx_valid, tx_req;
  wire [7:0] rx_data;
  wire trig_rise;
  wire sample_due;
  assign trig_rise = trig_mode & evt_s2_reg & ~evt_d_reg;
  assign sample_due = ~trig_mode & rtc_tick & (spacing_reg == 16'h0000)
    & (period_reg == 16'h0000) & (period_ticks != 16'h0000);
  // event pin is output only in free-running mode
  assign evt_out = evt_high_reg;
  assign evt_oe_n = trig_mode; // RQ8 RQ10
  // ****************************************
  // i2c slave, two addresses
  // ****************************************
  i2c_slave_core u_core
  (
    .clk(clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_oe_n(scl_oe_n), // RQ5 RQ6
    .sda_oe_n(sda_oe_n),
    .program_select_pin_addr(`PROGRAM_SELECT_PIN_ADDR), // RQ1 RQ3
    .app_addr(app_addr_out), // RQ2 RQ3
    .start_pulse(start_pulse),
    .stop_pulse(stop_pulse),
    .addr_hit(addr_hit),
    .sel_program_select_pin(sel_program_select_pin),
    .rd_mode(rd_mode),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ack(~sel_program_select_pin | program_select_pin), // RQ6
    .tx_req(tx_req),
    .tx_ready(1'b1),
    .tx_data(tx_byte)
  );
  // byte on offer follows the read order flag
  always @*
  begin
    tx_byte = rd_hi_reg ? distance_mm[15:8] : distance_mm[7:0];
  end
  // ****************************************
  // register side of i2c
  // ****************************************
  // any app write byte 0xfe arms an address change, next app write byte is address
  always @(posedge clk)
  begin
    if (rst)
    begin
      app_addr_out <= `APP_ADDR_RESET; // RQ2
      set_app_reg <= 1'b0;
      general_range_firmware_loaded <= 1'b0;
      fw_byte <= 8'h00;
      fw_byte_valid <= 1'b0;
      rd_hi_reg <= 1'b0;
    end
    else
    begin
      fw_byte_valid <= 1'b0;
      // low byte first, then high, then repeat
      if (start_pulse)
        rd_hi_reg <= 1'b0;
      else if (tx_req)
        rd_hi_reg <= ~rd_hi_reg;
      if (rx_valid & sel_program_select_pin & program_select_pin)
      begin
        fw_byte <= rx_data;
        fw_byte_valid <= 1'b1;
      end
      if (rx_valid & ~sel_program_select_pin)
      begin
        if (set_app_reg)
        begin
          // any valid 7-bit address, reserved ranges refused
          if (rx_data[6:3] != 4'h0 && rx_data[6:3] != 4'hf)
            app_addr_out <= rx_data[6:0]; // RQ2
          set_app_reg <= 1'b0;
        end
        else
          set_app_reg <= (rx_data == 8'hfe);
      end
      // image done when a programming write stops
      if (stop_pulse & sel_program_select_pin & ~rd_mode & program_select_pin)
        general_range_firmware_loaded <= 1'b1;
    end
  end
  // ****************************************
  // rtc prescaler and sample pacing
  // ****************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      div_reg <= 16'h0000;
      rtc_tick <= 1'b0;
      spacing_reg <= 16'h0000;
      period_reg <= 16'h0000;
    end
    else
    begin
      rtc_tick <= (div_reg == 16'h0000); // RQ13
      div_reg <= (div_reg == 16'h0000) ? RTC_DIV - 16'd1 : div_reg - 16'd1;
      if (rtc_tick)
      begin
        // period 0 stops sampling: standby
        if (spacing_reg == 16'h0000)
        begin
          spacing_reg <= rtc_tick_spacing; // RQ12
          period_reg <= (period_reg == 16'h0000) ? period_ticks : period_reg - 16'd1;
        end
        else
          spacing_reg <= spacing_reg - 16'd1;
      end
      // shorter settings cut the running counts short
      if (~rtc_tick & (spacing_reg > rtc_tick_spacing))
        spacing_reg <= rtc_tick_spacing;
      if (~rtc_tick & (period_reg > period_ticks))
        period_reg <= period_ticks;
    end
  end
  // ****************************************
  // measurement sequencer
  // ****************************************
  // trigger path is synchroniser plus one edge: 3 cycles, inside the bound
  always @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= ST_IDLE;
      evt_s1_reg <= 1'b0; evt_s2_reg <= 1'b0; evt_d_reg <= 1'b0;
      echo_s1_reg <= 1'b0; echo_s2_reg <= 1'b0;
      tof_reg <= {TOF_W{1'b0}};
      distance_mm <= 16'h0000;
      pulse_reg <= 3'h0;
      evt_high_reg <= 1'b0;
      burst_out <= 1'b0;
      measuring <= 1'b0;
    end
    else
    begin
      evt_s1_reg <= evt_in; evt_s2_reg <= evt_s1_reg; evt_d_reg <= evt_s2_reg;
      echo_s1_reg <= echo_in; echo_s2_reg <= echo_s1_reg;
      burst_out <= 1'b0;
      if (pulse_reg != 3'h0)
        pulse_reg <= pulse_reg - 3'h1;
      else
        evt_high_reg <= 1'b0;
      case (st_reg)
        ST_IDLE:
        begin
          // no host action needed in free-running mode
          if (general_range_firmware_loaded & (sample_due | trig_rise)) // RQ8 RQ10 RQ11 RQ14
          begin
            st_reg <= ST_FLY;
            burst_out <= 1'b1;
            measuring <= 1'b1;
            tof_reg <= {TOF_W{1'b0}};
          end
        end
        ST_FLY:
        begin
          if (echo_s2_reg)
            st_reg <= ST_DONE;
          else if (rtc_tick & ~&tof_reg)
            tof_reg <= tof_reg + 1'b1; // RQ13
        end
        ST_DONE:
        begin
          st_reg <= ST_IDLE;
          measuring <= 1'b0;
          distance_mm <= dist_calc[16:1]; // RQ16
          // event fires on proximity or motion
          if (~trig_mode & (irq_on_proximity ? (dist_calc[16:1] < prox_limit_mm)
            : (dist_calc[16:1] != distance_mm))) // RQ9 RQ15
          begin
            evt_high_reg <= 1'b1;
            pulse_reg <= `EVT_PULSE_CYC;
          end
        end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end
  // ****************************************
  // distance arithmetic
  // ****************************************
  // tick is one microsecond at default divider, so mm is us times 0.343
  always @*
  begin
    dist_calc = ({{(32-TOF_W){1'b0}}, tof_reg} * {16'h0000, `SOUND_MPS}) / 32'd1000; // RQ16
  end
endmodule // ranger_host_port

/* File: ranger_regs.vh */
`ifndef RANGER_REGS_VH
`define RANGER_REGS_VH
// fixed firmware loading address
`define PROGRAM_SELECT_PIN_ADDR 7'h45
// in-application address after reset
`define APP_ADDR_RESET 7'h29
// sound speed, m/s
`define SOUND_MPS 16'd343
// trigger start bound, ns
`define TRIG_LAT_NS 1000
// clock period, ns
`define CLK_NS 25
// event pulse width in cycles, minus one
`define EVT_PULSE_CYC 3'd4
`endif

/* File: i2c_slave_core.v */
`timescale 1ns/100ps
// ****************************************
// byte-level i2c slave with stretch before ack
// ****************************************
module i2c_slave_core
(
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output wire scl_oe_n,
  output wire sda_oe_n,
  input wire [6:0] program_select_pin_addr,
  input wire [6:0] app_addr,
  output reg start_pulse,
  output reg stop_pulse,
  output reg addr_hit,
  output reg sel_program_select_pin,
  output reg rd_mode,
  output reg rx_valid,
  output reg [7:0] rx_data,
  input wire rx_ack,
  output reg tx_req,
  input wire tx_ready,
  input wire [7:0] tx_data
);
  // pin synchronisers, first stage read only by second
  reg scl_s1_reg, scl_s2_reg, scl_d_reg;
  reg sda_s1_reg, sda_s2_reg, sda_d_reg;
  reg [3:0] bit_reg;
  reg [7:0] sh_reg;
  reg stretch_reg;
  reg sda_low_reg;
  reg active_reg;
  reg addr_phase_reg;
  reg ack_phase_reg;
  reg ack_drive_reg;
  reg wait_rx_reg;
  wire scl_rise;
  wire scl_fall;
  assign scl_rise = scl_s2_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s2_reg & scl_d_reg;
  assign scl_oe_n = ~stretch_reg;
  assign sda_oe_n = ~sda_low_reg;
  // ****************************************
  // bit engine
  // ****************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      scl_s1_reg <= 1'b1; scl_s2_reg <= 1'b1; scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1; sda_s2_reg <= 1'b1; sda_d_reg <= 1'b1;
      bit_reg <= 4'h0; sh_reg <= 8'h00; stretch_reg <= 1'b0;
      sda_low_reg <= 1'b0; active_reg <= 1'b0; addr_phase_reg <= 1'b0;
      ack_phase_reg <= 1'b0; ack_drive_reg <= 1'b0; wait_rx_reg <= 1'b0;
      start_pulse <= 1'b0; stop_pulse <= 1'b0; addr_hit <= 1'b0;
      sel_program_select_pin <= 1'b0; rd_mode <= 1'b0; rx_valid <= 1'b0;
      rx_data <= 8'h00; tx_req <= 1'b0;
    end
    else
    begin
      scl_s1_reg <= scl_in; scl_s2_reg <= scl_s1_reg; scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in; sda_s2_reg <= sda_s1_reg; sda_d_reg <= sda_s2_reg;
      start_pulse <= 1'b0; stop_pulse <= 1'b0; addr_hit <= 1'b0;
      rx_valid <= 1'b0; tx_req <= 1'b0;
      if (scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg)
      begin
        // start or repeated start
        start_pulse <= 1'b1; active_reg <= 1'b1; addr_phase_reg <= 1'b1;
        bit_reg <= 4'h0; sda_low_reg <= 1'b0; stretch_reg <= 1'b0;
        ack_phase_reg <= 1'b0; wait_rx_reg <= 1'b0;
      end
      else if (scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg)
      begin
        // stop releases everything
        stop_pulse <= active_reg; active_reg <= 1'b0;
        sda_low_reg <= 1'b0; stretch_reg <= 1'b0; wait_rx_reg <= 1'b0;
      end
      else if (active_reg)
      begin
        if (wait_rx_reg)
        begin
          // stretched until the owner decides ack or nack
          if (!addr_phase_reg)
          begin
            wait_rx_reg <= 1'b0; stretch_reg <= 1'b0;
            ack_drive_reg <= 1'b1; sda_low_reg <= rx_ack;
            if (!rx_ack) active_reg <= 1'b0;
          end
        end
        else if (ack_phase_reg)
        begin
          if (stretch_reg & tx_ready & rd_mode & !ack_drive_reg)
          begin
            // next byte loaded, release and watch the ack
            sh_reg <= tx_data; stretch_reg <= 1'b0;
          end
          if (scl_rise & rd_mode & !ack_drive_reg)
          begin
            if (sda_s2_reg) active_reg <= 1'b0;
          end
          if (scl_fall)
          begin
            ack_phase_reg <= 1'b0; ack_drive_reg <= 1'b0; bit_reg <= 4'h0;
            sda_low_reg <= rd_mode & active_reg & ~sh_reg[7];
          end
        end
        else if (scl_rise & !(rd_mode & !addr_phase_reg))
        begin
          sh_reg <= {sh_reg[6:0], sda_s2_reg};
          bit_reg <= bit_reg + 4'h1;
        end
        else if (scl_fall)
        begin
          if (rd_mode & !addr_phase_reg)
          begin
            if (bit_reg == 4'h7)
            begin
              // stretch after 8th transmitted bit while next byte loads
              sda_low_reg <= 1'b0; stretch_reg <= 1'b1; ack_phase_reg <= 1'b1;
              tx_req <= 1'b1; bit_reg <= 4'h0;
            end
            else
            begin
              sh_reg <= {sh_reg[6:0], 1'b0};
              sda_low_reg <= ~sh_reg[6]; bit_reg <= bit_reg + 4'h1;
            end
          end
          else if (bit_reg == 4'h8)
          begin
            // 8th received bit, hold clock low before ack for data and read address bytes
            stretch_reg <= 1'b1; ack_phase_reg <= 1'b1;
            if (addr_phase_reg)
            begin
              addr_phase_reg <= 1'b0;
              if (sh_reg[7:1] == program_select_pin_addr || sh_reg[7:1] == app_addr)
              begin
                addr_hit <= 1'b1; sel_program_select_pin <= (sh_reg[7:1] == program_select_pin_addr);
                rd_mode <= sh_reg[0]; ack_drive_reg <= 1'b1; sda_low_reg <= 1'b1;
                if (sh_reg[0]) tx_req <= 1'b1;
                else stretch_reg <= 1'b0;
              end
              else
              begin
                active_reg <= 1'b0; stretch_reg <= 1'b0; ack_phase_reg <= 1'b0;
              end
            end
            else
            begin
              rx_valid <= 1'b1; rx_data <= sh_reg; wait_rx_reg <= 1'b1;
            end
          end
        end
      end
      // first data byte of a read loads during the address ack stretch
      if (active_reg & ack_phase_reg & ack_drive_reg & rd_mode & stretch_reg & tx_ready)
      begin
        sh_reg <= tx_data; stretch_reg <= 1'b0; ack_drive_reg <= 1'b0;
      end
    end
  end
endmodule // i2c_slave_core

/* File: ranger_host_port_properties.sv */
`timescale 1ns/100ps
// ****************************************
// port checker
// ****************************************
module ranger_host_port_properties
(
  input wire clk,
  input wire rst,
  input wire scl_oe_n,
  input wire sda_oe_n,
  input wire evt_in,
  input wire evt_out,
  input wire evt_oe_n,
  input wire trig_mode,
  input wire program_select_pin,
  input wire burst_out,
  input wire measuring,
  input wire general_range_firmware_loaded,
  input wire fw_byte_valid,
  input wire [6:0] app_addr_out
);
  // cycles since the event pin rose, saturating
  reg [3:0] since_rise_reg;
  always @(posedge clk)
  begin
    if (rst || $rose(evt_in))
      since_rise_reg <= 4'h0;
    else if (since_rise_reg != 4'hf)
      since_rise_reg <= since_rise_reg + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_state:
    assert property ($fell(rst) |-> scl_oe_n && sda_oe_n && app_addr_out == 7'h29)
    else $error("bad state after reset");
  a_evt_dir:
    assert property (evt_oe_n == trig_mode)
    else $error("event pin direction wrong");
  a_trig_start:
    assert property (trig_mode && $past(trig_mode) && general_range_firmware_loaded
      && !measuring && $rose(evt_in) |-> ##[1:6] burst_out) else $error("trigger not taken");
  a_trig_cause:
    assert property (trig_mode && burst_out |-> since_rise_reg <= 4'h7)
    else $error("burst without trigger");
  a_trig_unloaded:
    assert property (trig_mode && !general_range_firmware_loaded |-> !burst_out)
    else $error("burst before load");
  a_burst_pulse:
    assert property (burst_out |=> !burst_out) else $error("burst too long");
  a_evt_pulse:
    assert property ($rose(evt_out) |-> ##[1:8] !evt_out) else $error("event not a pulse");
  a_fw_select:
    assert property (fw_byte_valid |-> program_select_pin ##1 !fw_byte_valid)
    else $error("firmware byte without select");
  a_loaded_held:
    assert property (general_range_firmware_loaded |=> general_range_firmware_loaded)
    else $error("loaded flag dropped");
  a_stretch_len:
    assert property ($fell(scl_oe_n) |-> ##[1:4] scl_oe_n) else $error("stretch too long");
endmodule // ranger_host_port_properties

bind ranger_host_port ranger_host_port_properties chk
(
  .clk(clk),
  .rst(rst),
  .scl_oe_n(scl_oe_n),
  .sda_oe_n(sda_oe_n),
  .evt_in(evt_in),
  .evt_out(evt_out),
  .evt_oe_n(evt_oe_n),
  .trig_mode(trig_mode),
  .program_select_pin(program_select_pin),
  .burst_out(burst_out),
  .measuring(measuring),
  .general_range_firmware_loaded(general_range_firmware_loaded),
  .fw_byte_valid(fw_byte_valid),
  .app_addr_out(app_addr_out)
);

/* File: i2c_host_model.sv */
`timescale 1ns/100ps
// ****************************************
// open-drain i2c host, low = pull line
// ****************************************
module i2c_host_model
(
  input wire clk,
  input wire scl,
  input wire sda,
  output reg scl_drv_n,
  output reg sda_drv_n
);
  initial
  begin
    scl_drv_n = 1'b1;
    sda_drv_n = 1'b1;
  end
  task half_bit;
    repeat (4) @(negedge clk);
  endtask
  // release clock; wait out any stretch, bounded
  task scl_up;
    integer t;
  begin
    scl_drv_n = 1'b1;
    t = 0;
    repeat (2) @(negedge clk);
    while (scl !== 1'b1 && t < 400)
    begin
      @(negedge clk);
      t = t + 1;
    end
    repeat (2) @(negedge clk);
  end
  endtask
  // data set in low half, sampled late in high half
  task bit_io(input b, output r);
  begin
    sda_drv_n = b;
    half_bit;
    scl_up;
    r = sda;
    scl_drv_n = 1'b0;
    @(negedge clk);
  end
  endtask
  // msb first, then the acknowledge slot
  task byte_io(input [7:0] d, input ack_in, output [7:0] q, output ack);
    integer i;
    reg r;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      bit_io(d[i], r);
      q = {q[6:0], r};
    end
    bit_io(ack_in, ack);
  end
  endtask
  task bus_start;
  begin
    sda_drv_n = 1'b1;
    half_bit;
    scl_up;
    sda_drv_n = 1'b0;
    half_bit;
    scl_drv_n = 1'b0;
    @(negedge clk);
  end
  endtask
  task bus_stop;
  begin
    sda_drv_n = 1'b0;
    half_bit;
    scl_up;
    sda_drv_n = 1'b1;
    half_bit;
  end
  endtask
endmodule // i2c_host_model

/* File: tb_ranger_host_port.sv */
`timescale 1ns/100ps
// ****************************************
// testbench
// ****************************************
module tb_ranger_host_port;
  reg clk;
  reg rst = 1'b1;
  reg program_select_pin = 1'b0;
  reg trig_mode = 1'b1;
  reg irq_on_proximity = 1'b1;
  reg [15:0] prox_limit_mm = 16'hffff;
  reg [15:0] period_ticks = 16'h0000;
  reg [15:0] rtc_tick_spacing = 16'h0800;
  reg echo_in = 1'b0;
  reg tb_evt = 1'b0; // host drive of the event pin
  wire scl_oe_n, sda_oe_n, scl_drv_n, sda_drv_n, evt_out, evt_oe_n, burst_out;
  wire loaded, fw_byte_valid, measuring;
  wire [7:0] fw_byte;
  wire [6:0] app_addr_out;
  wire [15:0] distance_mm;
  // pulled-up wires, low if either side pulls
  wire scl = scl_oe_n & scl_drv_n;
  wire sda = sda_oe_n & sda_drv_n;
  wire evt_in = evt_oe_n ? tb_evt : evt_out;
  integer n_fail = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer n_burst = 0;
  integer n_evt = 0;
  integer n_fw = 0;
  integer echo_cnt = 0;
  integer echo_gap = 4000; // 1000 ticks at four cycles a tick
  integer t;
  reg evt_d = 1'b0;
  reg [7:0] last_fw = 8'h00;
  reg [2:0] ak;
  reg [15:0] rdv, b0, e0;
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  i2c_host_model host (.clk(clk), .scl(scl), .sda(sda), .scl_drv_n(scl_drv_n),
    .sda_drv_n(sda_drv_n));
  ranger_host_port #(.RTC_DIV(16'h0004), .TOF_W(16)) dut (.clk(clk), .rst(rst),
    .scl_in(scl), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_oe_n(sda_oe_n),
    .evt_in(evt_in), .evt_out(evt_out), .evt_oe_n(evt_oe_n),
    .program_select_pin(program_select_pin), .trig_mode(trig_mode),
    .irq_on_proximity(irq_on_proximity), .prox_limit_mm(prox_limit_mm),
    .period_ticks(period_ticks), .rtc_tick_spacing(rtc_tick_spacing), .echo_in(echo_in),
    .burst_out(burst_out), .general_range_firmware_loaded(loaded), .fw_byte(fw_byte),
    .fw_byte_valid(fw_byte_valid), .app_addr_out(app_addr_out),
    .distance_mm(distance_mm), .measuring(measuring));
  // event counters and the hang limit
  always @(negedge clk)
  begin
    cyc = cyc + 1;
    if (burst_out === 1'b1)
      n_burst = n_burst + 1;
    if (evt_out === 1'b1 && evt_d !== 1'b1)
      n_evt = n_evt + 1;
    evt_d = evt_out;
    if (fw_byte_valid === 1'b1)
    begin
      n_fw = n_fw + 1;
      last_fw = fw_byte;
    end
    if (cyc == 60000)
    begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  // echo is high for the last four of the echo_gap cycles after each burst
  always @(negedge clk)
  begin
    if (burst_out === 1'b1)
      echo_cnt = echo_gap;
    else if (echo_cnt > 0)
      echo_cnt = echo_cnt - 1;
    echo_in = (echo_cnt > 0) && (echo_cnt <= 4);
  end
  task check(input [15:0] seen, input [15:0] exp);
  begin
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // write n data bytes; ak holds the three ack slots, 1 = nack
  task wr(input [6:0] a, input [7:0] d0, input [7:0] d1, input integer n, output [2:0] k);
    reg [7:0] q;
  begin
    k = 3'h7;
    host.bus_start;
    host.byte_io({a, 1'b0}, 1'b1, q, k[0]);
    if (n > 0)
      host.byte_io(d0, 1'b1, q, k[1]);
    if (n > 1)
      host.byte_io(d1, 1'b1, q, k[2]);
    host.bus_stop;
  end
  endtask
  // read the two distance bytes, low first
  task rd(input [6:0] a, output [15:0] v);
    reg k;
  begin
    host.bus_start;
    host.byte_io({a, 1'b1}, 1'b1, v[7:0], k);
    check(k, 0);
    host.byte_io(8'hff, 1'b0, v[7:0], k);
    host.byte_io(8'hff, 1'b1, v[15:8], k);
    host.bus_stop;
  end
  endtask
  task close_out;
  begin
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(app_addr_out, 16'h0029);
    tb_evt = 1'b1;
    repeat (40) @(negedge clk);
    tb_evt = 1'b0;
    check(n_burst[15:0], 16'h0000);
    wr(7'h11, 8'h00, 8'h00, 0, ak);
    check(ak, 3'h7);
    wr(7'h45, 8'h5a, 8'h00, 1, ak);
    check({ak, n_fw[7:0]}, 16'h0600);
    program_select_pin = 1'b1;
    wr(7'h45, 8'ha5, 8'h3c, 2, ak);
    check({ak, n_fw[4:0], last_fw}, 16'h023c);
    check(loaded, 1);
    wr(7'h29, 8'hfe, 8'h30, 2, ak);
    check({ak, 6'h00, app_addr_out}, 16'h0030);
    wr(7'h29, 8'h00, 8'h00, 0, ak);
    check(ak, 3'h7);
    wr(7'h45, 8'h00, 8'h00, 0, ak);
    check(ak[0], 0);
    b0 = n_burst[15:0];
    tb_evt = 1'b1;
    t = 0;
    while (burst_out !== 1'b1 && t < 40)
    begin
      @(negedge clk);
      t = t + 1;
    end
    check(t < 40, 1);
    repeat (4) @(negedge clk);
    tb_evt = 1'b0;
    repeat (100) @(negedge clk);
    tb_evt = 1'b1;
    repeat (4) @(negedge clk);
    tb_evt = 1'b0;
    t = 0;
    while (measuring !== 1'b0 && t < 6000)
    begin
      @(negedge clk);
      t = t + 1;
    end
    repeat (8) @(negedge clk);
    check(n_burst[15:0] - b0, 16'h0001);
    check(distance_mm, 16'h00ab);
    rd(7'h30, rdv);
    check(rdv, 16'h00ab);
    repeat (200) @(negedge clk);
    check(n_burst[15:0] - b0, 16'h0001);
    echo_gap = 40;
    trig_mode = 1'b0;
    period_ticks = 16'h0018;
    rtc_tick_spacing = 16'h0001;
    b0 = n_burst[15:0];
    e0 = n_evt[15:0];
    repeat (2000) @(negedge clk);
    period_ticks = 16'h0000;
    rtc_tick_spacing = 16'h0800;
    repeat (300) @(negedge clk);
    check((n_burst[15:0] - b0 >= 16'h0009) && (n_burst[15:0] - b0 <= 16'h000b), 1);
    check(n_evt[15:0] - e0, n_burst[15:0] - b0);
    b0 = n_burst[15:0];
    repeat (1000) @(negedge clk);
    check(n_burst[15:0], b0);
    irq_on_proximity = 1'b0;
    period_ticks = 16'h0018;
    rtc_tick_spacing = 16'h0001;
    b0 = n_burst[15:0];
    e0 = n_evt[15:0];
    repeat (1000) @(negedge clk);
    check(n_burst[15:0] - b0 >= 16'h0004, 1);
    check(n_evt[15:0] - e0, 16'h0000);
    close_out;
  end
endmodule // tb_ranger_host_port
